// ---- ssp_map.svh ----
// ssp_map.svh - constants of the synchronous burst sram port
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// =====================================================================
// widths
`define SSP_LANES      4
`define SSP_BYTE_W     8
`define SSP_LANE_W     9
`define SSP_ADDR_W     18
`define SSP_STEP_W     2

// =====================================================================
// values
`define SSP_STEP_ONE   2'h1
`define SSP_STEP_ZERO  2'h0
`define SSP_BE_ALL     4'hf
`define SSP_BE_NONE    4'h0

// =====================================================================
// state codes, gray along desel -> first -> burst
`define SSP_ST_DESEL   2'h0
`define SSP_ST_FIRST   2'h1
`define SSP_ST_BURST   2'h3

// =====================================================================
// reset values of the async input synchronisers {oe_n, sleep, order}
`define SSP_ASYNC_RST  3'h5
`define SSP_RST_PIPE   2'h0

`endif

// ---- ssp_pkg.sv ----
// ssp_pkg.sv - types of the synchronous burst sram port
`include "ssp_map.svh"

package ssp_pkg;

    // =================================================================
    // data word as it sits on the data and parity pins
    typedef struct packed {
        logic [`SSP_LANES-1:0]            par;
        logic [`SSP_LANES*`SSP_BYTE_W-1:0] data;
    } ssp_word_t;

    // =================================================================
    // the three chip selects as sampled together
    typedef struct packed {
        logic one_n;
        logic two;
        logic three_n;
    } ssp_cs_t;

    // =================================================================
    // cycle tracker states
    typedef enum logic [1:0] {
        ssp_st_desel = `SSP_ST_DESEL,
        ssp_st_first = `SSP_ST_FIRST,
        ssp_st_burst = `SSP_ST_BURST
    } ssp_state_t;

endpackage

// ---- ssp_mem.sv ----
// ssp_mem.sv - byte-lane storage array with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"

module ssp_mem #(
    parameter int AW    = `SSP_ADDR_W,
    parameter int LANES = `SSP_LANES,
    parameter int LW    = `SSP_LANE_W
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic [AW-1:0]       addr,
    input  wire logic [LANES-1:0]    wr_en,
    input  wire logic [LANES*LW-1:0] wr_data,
    output var  logic [LANES*LW-1:0] rd_data
);

    // =================================================================
    // one array per lane, write and read at the same address
    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_lane
            logic [LW-1:0] ram [2**AW];

            // lane write, contents are never cleared
            always_ff @(posedge mclk) begin
                if (wr_en[i]) begin
                    ram[addr] <= wr_data[i*LW +: LW];
                end
            end

            // read register, reset so the output is defined
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    rd_data[i*LW +: LW] <= '0;
                end else begin
                    rd_data[i*LW +: LW] <= ram[addr];
                end
            end
        end
    endgenerate

endmodule // ssp_mem

`default_nettype wire

// ---- ssp_port.sv ----
// ssp_port.sv - synchronous flow-through burst sram port logic
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"

module ssp_port #(
    parameter int AW = `SSP_ADDR_W
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    // address and strobes
    input  wire logic [AW-1:0]     addr_in,
    input  wire logic              processor_addr_strobe_n,
    input  wire logic              controller_addr_strobe_n,
    input  wire logic              burst_step_n,
    input  wire ssp_pkg::ssp_cs_t  chip_sel,
    // write qualifiers
    input  wire logic [`SSP_LANES-1:0] byte_lane_select_n,
    input  wire logic              byte_write_qualifier_n,
    input  wire logic              global_write_all_n,
    // asynchronous controls
    input  wire logic              output_enable_n,
    input  wire logic              sleep_input,
    input  wire logic              burst_order,
    // data and parity pins, split into three signals
    input  wire ssp_pkg::ssp_word_t dq_in,
    output var  ssp_pkg::ssp_word_t dq_out,
    output var  logic              dq_oe_n,
    // status
    output var  logic              sleep_active,
    output var  logic              cycle_active
);
    import ssp_pkg::*;

    localparam int LW = `SSP_LANE_W;
    localparam int NL = `SSP_LANES;

    // =================================================================
    // reset release
    logic [1:0] rst_pipe_q;
    logic       rst_n;

    // async reset, released through two flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe_q <= `SSP_RST_PIPE;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_q[1];

    // =================================================================
    // asynchronous input synchronisers
    logic [2:0] async_meta_q;
    logic [2:0] async_sync_q;
    logic       oe_n_s;
    logic       sleep_s;
    logic       order_s;

    // two flops, first one read only by the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            async_meta_q <= `SSP_ASYNC_RST;
            async_sync_q <= `SSP_ASYNC_RST;
        end else begin
            async_meta_q <= {output_enable_n, sleep_input, burst_order};
            async_sync_q <= async_meta_q;
        end
    end

    assign oe_n_s  = async_sync_q[2];
    assign sleep_s = async_sync_q[1];
    assign order_s = async_sync_q[0];   // static strap

    // =================================================================
    // chip select and strobe decode
    logic selected;
    logic p_take;
    logic c_take;
    logic any_take;
    logic start;
    logic desel;
    logic from_proc;

    // all three selects active
    assign selected = !chip_sel.one_n && chip_sel.two && !chip_sel.three_n;
    // processor strobe needs select one low
    assign p_take   = !processor_addr_strobe_n && !chip_sel.one_n;
    assign c_take   = !controller_addr_strobe_n;
    assign any_take = !sleep_s && (p_take || c_take);
    // address captured only when fully selected
    assign start    = any_take && selected;
    assign desel    = any_take && !selected;
    // processor strobe wins when both are low
    assign from_proc = p_take;

    // =================================================================
    // cycle tracker
    ssp_state_t state_q;
    ssp_state_t state_d;
    logic       in_cycle;

    assign in_cycle = (state_q != ssp_st_desel);

    // next state, first clock after deselect is marked
    always_comb begin
        state_d = state_q;
        case (state_q)
            ssp_st_desel: begin
                if (start) begin
                    state_d = ssp_st_first;
                end
            end
            ssp_st_first: begin
                if (desel) begin
                    state_d = ssp_st_desel;
                end else if (!sleep_s) begin
                    state_d = ssp_st_burst;
                end
            end
            ssp_st_burst: begin
                if (desel) begin
                    state_d = ssp_st_desel;
                end
            end
            default: begin
                state_d = ssp_st_desel;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ssp_st_desel;
        end else begin
            state_q <= state_d;
        end
    end

    // =================================================================
    // burst counter and address
    logic [AW-1:0]          addr_q;
    logic [AW-1:0]          addr_d;
    logic [`SSP_STEP_W-1:0] seed_q;
    logic [`SSP_STEP_W-1:0] seed_d;
    logic [`SSP_STEP_W-1:0] step_q;
    logic [`SSP_STEP_W-1:0] step_d;
    logic [`SSP_STEP_W-1:0] step_nx;
    logic [`SSP_STEP_W-1:0] low_lin;
    logic [`SSP_STEP_W-1:0] low_il;
    logic [`SSP_STEP_W-1:0] low_nx;
    logic                   advance;

    // step only inside a cycle and with no new strobe
    assign advance = in_cycle && !burst_step_n && !any_take && !sleep_s;
    assign step_nx = step_q + `SSP_STEP_ONE;   // wraps at four
    assign low_lin = seed_q + step_nx;
    assign low_il  = seed_q ^ step_nx;
    // strap low picks linear, high picks interleaved
    assign low_nx  = order_s ? low_il : low_lin;

    // next address, new start or next burst word
    assign addr_d = start   ? addr_in :
                    advance ? {addr_q[AW-1:`SSP_STEP_W], low_nx} :
                              addr_q;

    // counter seed from the low address bits on a start
    assign seed_d = start   ? addr_in[`SSP_STEP_W-1:0] : seed_q;
    // step count cleared on a start, bumped on an advance
    assign step_d = start   ? `SSP_STEP_ZERO :
                    advance ? step_nx :
                              step_q;

    // address and counter registers, loaded every edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            seed_q <= `SSP_STEP_ZERO;
            step_q <= `SSP_STEP_ZERO;
        end else begin
            addr_q <= addr_d;
            seed_q <= seed_d;
            step_q <= step_d;
        end
    end

    // =================================================================
    // write qualification
    logic            wr_ok;
    logic [NL-1:0]   lane_be;
    logic [NL-1:0]   wr_en;

    // processor strobe edge is a read start, no write there
    assign wr_ok   = !sleep_s && !desel &&
                     ((start && !from_proc) || (!any_take && in_cycle));
    // global write beats lane selects
    // lanes only with byte qualifier low
    assign lane_be = !global_write_all_n     ? `SSP_BE_ALL :
                     !byte_write_qualifier_n ? ~byte_lane_select_n :
                                               `SSP_BE_NONE;
    // write lands at this very edge
    assign wr_en   = wr_ok ? lane_be : `SSP_BE_NONE;

    // =================================================================
    // lane packing between pin word and storage lanes
    logic [NL*LW-1:0] wr_lanes;
    logic [NL*LW-1:0] rd_lanes;
    ssp_word_t        rd_word;

    genvar g;
    generate
        for (g = 0; g < NL; g++) begin : g_pack
            // pin data captured into the write lanes
            assign wr_lanes[g*LW +: LW] =
                {dq_in.par[g], dq_in.data[g*`SSP_BYTE_W +: `SSP_BYTE_W]};
            assign rd_word.par[g] = rd_lanes[g*LW + `SSP_BYTE_W];
            assign rd_word.data[g*`SSP_BYTE_W +: `SSP_BYTE_W] =
                rd_lanes[g*LW +: `SSP_BYTE_W];
        end
    endgenerate

    // =================================================================
    // storage, read data registered at the addressing edge
    ssp_mem #(
        .AW    (AW),
        .LANES (NL),
        .LW    (LW)
    ) u_mem (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .addr    (addr_d),
        .wr_en   (wr_en),
        .wr_data (wr_lanes),
        .rd_data (rd_lanes)
    );

    // flow-through, word of the previous edge on the pins
    assign dq_out = rd_word;

    // =================================================================
    // output enable
    logic drive_d;
    logic first_d;
    logic busy_d;
    logic oe_n_q;

    // entering the first clock out of deselect, reads and writes alike
    assign first_d = (state_d == ssp_st_first);
    assign busy_d  = (state_d != ssp_st_desel);

    // drive while enable low, masked on first clock
    // sleep releases the pins even with enable low
    assign drive_d = !oe_n_s && !first_d && !sleep_s;

    // pin enable register, released out of reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= !drive_d;
        end
    end

    assign dq_oe_n = oe_n_q;

    // =================================================================
    // status outputs

    // synced sleep level seen by the host
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_active <= 1'b0;
        end else begin
            sleep_active <= sleep_s;
        end
    end

    // high while a cycle is open, low once deselected
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_active <= 1'b0;
        end else begin
            cycle_active <= busy_d;
        end
    end

endmodule // ssp_port

`default_nettype wire

// ---- ssp_port_sva.sv ----
// ssp_port_sva.sv - assertion checker on the pins of the burst sram port
`timescale 1ns/1ps
`default_nettype none
module ssp_port_sva (
    input wire logic              mclk,
    input wire logic              rstn,
    input wire logic              processor_addr_strobe_n,
    input wire logic              controller_addr_strobe_n,
    input wire logic              burst_step_n,
    input wire ssp_pkg::ssp_cs_t  chip_sel,
    input wire logic              byte_write_qualifier_n,
    input wire logic              global_write_all_n,
    input wire logic              output_enable_n,
    input wire logic              sleep_input,
    input wire ssp_pkg::ssp_word_t dq_out,
    input wire logic              dq_oe_n,
    input wire logic              sleep_active,
    input wire logic              cycle_active
);
    import ssp_pkg::*;
    logic [2:0] rdy_q;
    logic       rdy, sel, start, nowr, idle;
    // =================================================================
    // settle window after reset, syncs need a few edges
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            rdy_q <= 3'h0;
        else if (!rdy)
            rdy_q <= rdy_q + 3'h1;
    end
    // decoded view of the sampled controls
    assign rdy   = (rdy_q == 3'h7);
    assign sel   = !chip_sel.one_n && chip_sel.two && !chip_sel.three_n;
    assign start = sel && (!controller_addr_strobe_n
                   || (!processor_addr_strobe_n && !chip_sel.one_n));
    assign nowr  = global_write_all_n && byte_write_qualifier_n;
    assign idle  = nowr && processor_addr_strobe_n && controller_addr_strobe_n && burst_step_n;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // =================================================================
    // properties
    a_first_mask: assert property (
        (!sleep_input)[*4] ##0 (rdy && !cycle_active && start) |=> dq_oe_n)
        else $error("pins driven on first clock after deselect");
    a_oe_release: assert property (output_enable_n[*3] ##0 rdy |=> dq_oe_n)
        else $error("pins driven while output enable high");
    a_oe_drive: assert property (
        (!output_enable_n && !sleep_input)[*4] ##0 (rdy && cycle_active
        && processor_addr_strobe_n && controller_addr_strobe_n) |=> !dq_oe_n)
        else $error("pins not driven while output enable low");
    a_sleep_on: assert property (sleep_input[*4] ##0 rdy |-> sleep_active)
        else $error("sleep not entered");
    a_sleep_off: assert property ((!sleep_input)[*4] ##0 rdy |-> !sleep_active)
        else $error("sleep not left");
    a_sleep_float: assert property (sleep_active[*2] |-> dq_oe_n)
        else $error("pins driven in sleep");
    a_cycle_start: assert property (
        (!sleep_input)[*4] ##0 (rdy && start) |=> cycle_active)
        else $error("selected strobe started no cycle");
    a_desel_seen: assert property (
        (!sleep_input)[*4] ##0 (rdy && !controller_addr_strobe_n && !sel) |=> !cycle_active)
        else $error("unselected strobe kept cycle");
    a_proc_ignored: assert property (rdy && chip_sel.one_n && controller_addr_strobe_n
        |=> $stable(cycle_active)) else $error("processor strobe acted with select one high");
    a_read_hold: assert property (rdy && idle && $past(nowr) |=> $stable(dq_out))
        else $error("read data moved without new address or write");
endmodule // ssp_port_sva

bind ssp_port ssp_port_sva i_ssp_port_sva (
    .mclk(mclk), .rstn(rstn), .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n), .burst_step_n(burst_step_n),
    .chip_sel(chip_sel), .byte_write_qualifier_n(byte_write_qualifier_n),
    .global_write_all_n(global_write_all_n), .output_enable_n(output_enable_n),
    .sleep_input(sleep_input), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .sleep_active(sleep_active), .cycle_active(cycle_active)
);
`default_nettype wire

// ---- ssp_host_pins.sv ----
// ssp_host_pins.sv - host side of the shared data and parity pins
`timescale 1ns/1ps
`default_nettype none
module ssp_host_pins (
    input  wire logic               mclk,
    input  wire logic               host_en,
    input  wire ssp_pkg::ssp_word_t host_data,
    input  wire ssp_pkg::ssp_word_t dq_out,
    input  wire logic               dq_oe_n,
    output var  ssp_pkg::ssp_word_t dq_in
);
    import ssp_pkg::*;
    ssp_word_t last_q;
    // =================================================================
    // last wire level, so an undriven bus never repeats it
    always_ff @(posedge mclk) begin
        last_q <= dq_in;
    end
    // wire level: host first, then the port, else a changing pattern
    assign dq_in = host_en ? host_data : (!dq_oe_n ? dq_out : ~last_q);
endmodule // ssp_host_pins
`default_nettype wire

// ---- test_sync_burst_sram_port.sv ----
// test_sync_burst_sram_port.sv - self-checking bench for the burst sram port
`timescale 1ns/1ps
`default_nettype none
module test_sync_burst_sram_port;
    import ssp_pkg::*;
    logic        mclk, rstn, p_n, c_n, st_n, ga_n, bq_n, oe_n, slp, ord, dq_oe_n, sa, ca;
    logic [3:0]  ln_n;
    logic [5:0]  a;
    ssp_cs_t     cs;
    ssp_word_t   hd, dqi, dqo;
    logic [35:0] shadow [64];
    int          failures, num_checks;
    // =================================================================
    // port under test, short address, and the host pin model
    ssp_port #(.AW(6)) i_ssp_port (
        .mclk(mclk), .rstn(rstn), .addr_in(a), .processor_addr_strobe_n(p_n),
        .controller_addr_strobe_n(c_n), .burst_step_n(st_n), .chip_sel(cs),
        .byte_lane_select_n(ln_n), .byte_write_qualifier_n(bq_n), .global_write_all_n(ga_n),
        .output_enable_n(oe_n), .sleep_input(slp), .burst_order(ord), .dq_in(dqi),
        .dq_out(dqo), .dq_oe_n(dq_oe_n), .sleep_active(sa), .cycle_active(ca));
    ssp_host_pins i_ssp_host_pins (.mclk(mclk), .host_en(oe_n), .host_data(hd),
        .dq_out(dqo), .dq_oe_n(dq_oe_n), .dq_in(dqi));
    // 100 mhz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // =================================================================
    // helpers
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic step(input logic p, c, v, g, e, input logic [3:0] b, input logic [5:0] ad,
                        input logic [35:0] d);
        {p_n, c_n, st_n, ga_n, bq_n, ln_n, a, hd} = {p, c, v, g, e, b, ad, d};
        @(posedge mclk);
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) step(1, 1, 1, 1, 1, 4'hf, a, hd);
    endtask
    function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] b);
        for (int i = 0; i < 4; i++) begin
            if (!b[i]) begin
                o[8*i +: 8] = n[8*i +: 8];
                o[32+i]     = n[32+i];
            end
        end
        return o;
    endfunction
    task automatic do_reset(input logic o);
        rstn = 1'b0;
        ord  = o; // strap only moves while reset is held
        repeat (12) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (6) @(posedge mclk);
        #1;
    endtask
    task automatic rd_burst(input logic [5:0] ad, input logic o);
        logic [1:0] lo;
        step(1, 0, 1, 1, 1, 4'hf, ad, '0);
        chk("burst start", dqo, shadow[ad]);
        for (int s = 1; s < 5; s++) begin
            lo = o ? (ad[1:0] ^ s[1:0]) : (ad[1:0] + s[1:0]);
            step(1, 1, 0, 1, 1, 4'hf, ad, '0);
            chk("burst step", dqo, shadow[{ad[5:2], lo}]);
        end
    endtask
    // =================================================================
    // scenarios
    task automatic t_write;
        for (int i = 0; i < 64; i++) begin
            shadow[i] = 36'h9_3715_b2c1 ^ {6{i[5:0]}};
            step(1, 0, 1, 0, 1, 4'hf, i[5:0], shadow[i]);
        end
        step(1, 0, 1, 0, 1, 4'hf, 6'h05, 36'h1_1111_1111);
        shadow[5] = 36'h1_1111_1111;
        step(1, 1, 0, 1, 0, 4'hc, 6'h05, 36'h2_2222_2222); // partial write
        shadow[6] = merge(shadow[6], 36'h2_2222_2222, 4'hc);
        step(1, 1, 0, 1, 1, 4'h0, 6'h05, 36'h3_3333_3333); // lanes alone write nothing
        step(1, 1, 0, 0, 1, 4'hf, 6'h05, 36'h4_4444_4444);
        shadow[4] = 36'h4_4444_4444;
        rd_burst(6'h05, 1'b0);
        $display("done write and linear burst");
    endtask
    task automatic t_strobes;
        step(1, 0, 1, 1, 1, 4'hf, 6'h10, '0);
        cs.one_n = 1'b1;
        step(0, 1, 1, 1, 1, 4'hf, 6'h20, '0);
        chk("ignored addr", dqo, shadow[16]);
        chk("ignored cycle", ca, 1'b1);
        cs.one_n = 1'b0;
        step(0, 0, 1, 0, 1, 4'hf, 6'h21, '1);
        chk("both strobes", dqo, shadow[33]);
        step(1, 0, 1, 1, 1, 4'hf, 6'h21, '0);
        chk("no write", dqo, shadow[33]);
        step(0, 1, 1, 0, 1, 4'hf, 6'h22, '1);
        chk("proc start", dqo, shadow[34]);
        step(1, 0, 1, 1, 1, 4'hf, 6'h22, '0);
        chk("proc no write", dqo, shadow[34]);
        for (int i = 0; i < 8; i++) begin
            cs = 3'b010;
            step(1, 0, 1, 1, 1, 4'hf, 6'h30, '0);
            cs = i[2:0];
            step(1, 0, 1, 1, 1, 4'hf, 6'h31, '0);
            chk("select", ca, i == 2);
        end
        cs = 3'b010;
        $display("done strobes and selects");
    endtask
    task automatic t_sleep;
        slp  = 1'b1;
        oe_n = 1'b0;
        idle(4);
        chk("sleep", sa, 1'b1);
        chk("sleep pins", dq_oe_n, 1'b1);
        oe_n = 1'b1;
        step(1, 0, 1, 0, 1, 4'hf, 6'h03, '0);
        slp = 1'b0;
        idle(4);
        chk("wake", sa, 1'b0);
        step(1, 0, 1, 1, 1, 4'hf, 6'h03, '0);
        chk("kept", dqo, shadow[3]);
        $display("done sleep");
    endtask
    task automatic t_oe;
        oe_n = 1'b0;
        cs.two = 1'b0;
        step(1, 0, 1, 1, 1, 4'hf, 6'h08, '0);
        cs.two = 1'b1;
        idle(3);
        chk("desel drive", dq_oe_n, 1'b0);
        step(1, 0, 1, 1, 1, 4'hf, 6'h08, '0);
        chk("mask", dq_oe_n, 1'b1);
        step(1, 1, 0, 1, 1, 4'hf, 6'h08, '0);
        chk("drive", dq_oe_n, 1'b0);
        chk("pins", dqi, shadow[9]);
        oe_n = 1'b1;
        idle(3);
        chk("release", dq_oe_n, 1'b1);
        $display("done output enable");
    endtask
    // =================================================================
    // verdict and main sequence
    task automatic close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {p_n, c_n, st_n, ga_n, bq_n, oe_n, ln_n} = '1;
        {a, hd, ord, rstn, slp} = '0;
        cs         = 3'b010;
        failures   = 0;
        num_checks = 0;
        do_reset(1'b0);
        t_write;
        t_strobes;
        t_sleep;
        t_oe;
        do_reset(1'b1);
        rd_burst(6'h26, 1'b1);
        $display("done interleaved burst");
        close_out;
    end
    // watchdog, well past the about 155 cycles the run needs
    initial begin
        #20000;
        failures++;
        close_out;
    end
endmodule // test_sync_burst_sram_port
`default_nettype wire
